/* File: src/pss_pkg.sv */
package pss_pkg;

	// pin and mode carriers
	typedef enum logic [2:0]
	{
		PSS_OFF     = 3'b000,
		PSS_RESET   = 3'b001,
		PSS_DEFAULT = 3'b011,
		PSS_DOZE    = 3'b010,
		PSS_RX      = 3'b110,
		PSS_TX      = 3'b111
	} pss_state_type;

	typedef enum logic [1:0]
	{
		PSS_ACT_DOZE = 2'b00,
		PSS_ACT_RX   = 2'b01,
		PSS_ACT_TX   = 2'b10
	} pss_activity_type;

	localparam int PSS_PADS = 9;

	typedef struct packed
	{
		logic [PSS_PADS-1:0] out_en;
		logic [PSS_PADS-1:0] in_en;
		logic [PSS_PADS-1:0] pull_en;
	} pss_pad_ctl_type;

	localparam logic [PSS_PADS-1:0] PSS_ALL_OFF = '0;
	localparam logic [PSS_PADS-1:0] PSS_ALL_ON  = '1;

endpackage : pss_pkg

/* File: src/pss_sync.sv */
`timescale 1ns/100ps
module pss_sync
#(
	parameter int WIDTH = 1
)
(
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] meta_r;

	// a zero-width bank has no flops to carry a level
	if (WIDTH < 1)
	begin : g_bad_width
		$error("pss_sync needs a width of at least one");
	end

	// meta_r feeds only dout
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			meta_r <= '0;
			dout   <= '0;
		end
		else
		begin
			meta_r <= din;
			dout   <= meta_r;
		end
	end
endmodule : pss_sync

/* File: src/pss_top.sv */
`timescale 1ns/100ps
// How it works
// - core converter runs only while enable high
// - power-down: pads hi-z, inputs, pulls off
// - reset phase: hi-z, inputs off, pulls on
// - unconfigured: hi-z, inputs and pulls on
// - operating splits into transmit, receive, idle
module pss_top
(
	input  wire logic                          CORE_CLK,
	input  wire logic                          SYS_RST,
	input  wire logic                          CHIP_ENABLE,
	input  wire logic                          ACTIVE_LOW_RESET_PIN_N,
	input  wire logic                          IO_SUPPLY_GOOD,
	input  wire logic                          FW_CONFIGURED,
	input  wire logic [pss_pkg::PSS_PADS-1:0]  FW_OUT_EN,
	input  wire logic [pss_pkg::PSS_PADS-1:0]  FW_PULL_EN,
	input  wire pss_pkg::pss_activity_type     FW_ACTIVITY,
	output logic                               CORE_CONVERTER_ON,
	output pss_pkg::pss_pad_ctl_type           PAD_CTL,
	output pss_pkg::pss_state_type             POWER_STATE
);
	import pss_pkg::*;

	logic          en_s;
	logic          rstn_s;
	logic          io_s;
	pss_state_type state_r;
	pss_state_type state_nxt;
	pss_pad_ctl_type pad_nxt;
	logic                powered;
	logic                held;
	logic                released;
	pss_state_type       run_state;
	logic                pads_quiet;
	logic                pads_held;
	logic                pads_default;
	logic                pads_fw;
	logic [PSS_PADS-1:0] out_nxt;
	logic [PSS_PADS-1:0] in_nxt;
	logic [PSS_PADS-1:0] pull_nxt;

	// an empty pad bank would leave the enable vectors without a bit
	if (PSS_PADS < 1)
	begin : g_bad_pads
		$error("pss_top needs at least one pad");
	end

	// pin levels come from outside the core clock domain
	pss_sync #(.WIDTH(3)) u_sync
	(
		.clk  (CORE_CLK),
		.rst  (SYS_RST),
		.din  ({CHIP_ENABLE, ACTIVE_LOW_RESET_PIN_N, IO_SUPPLY_GOOD}),
		.dout ({en_s, rstn_s, io_s})
	);

	// pin levels reduced to the three questions the state decode asks
	assign powered  = io_s && en_s;
	assign held     = powered && !rstn_s;
	assign released = powered && rstn_s;

	// firmware activity picks the operating sub-state; the spare code idles
	always_comb
	begin
		run_state = PSS_DOZE;
		case (FW_ACTIVITY)
			PSS_ACT_TX:
			begin
				run_state = PSS_TX;
			end
			PSS_ACT_RX:
			begin
				run_state = PSS_RX;
			end
			PSS_ACT_DOZE:
			begin
				run_state = PSS_DOZE;
			end
			default:
			begin
				run_state = PSS_DOZE;
			end
		endcase
	end

	// supply, enable and reset levels, FW_CONFIGURED and FW_ACTIVITY pick the state; the host keeps the order
	always_comb
	begin
		state_nxt = PSS_OFF;
		if (held)
		begin
			state_nxt = PSS_RESET;
		end
		else if (released && !FW_CONFIGURED)
		begin
			state_nxt = PSS_DEFAULT;
		end
		else if (released)
		begin
			state_nxt = run_state;
		end
	end

	always_ff @(posedge CORE_CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
			state_r <= PSS_OFF;
		else
			state_r <= state_nxt;
	end

	// converter follows the synchronised enable level
	always_ff @(posedge CORE_CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
			CORE_CONVERTER_ON <= 1'b0;
		else
			CORE_CONVERTER_ON <= en_s;
	end

	// one flag per pad regime; decoded from the next state so the pads
	// change on the same edge as POWER_STATE
	always_comb
	begin
		pads_quiet   = 1'b0;
		pads_held    = 1'b0;
		pads_default = 1'b0;
		pads_fw      = 1'b0;
		case (state_nxt)
			PSS_OFF:
			begin
				pads_quiet = 1'b1;
			end
			PSS_RESET:
			begin
				pads_held = 1'b1;
			end
			PSS_DEFAULT:
			begin
				pads_default = 1'b1;
			end
			PSS_DOZE:
			begin
				pads_fw = 1'b1;
			end
			PSS_RX:
			begin
				pads_fw = 1'b1;
			end
			PSS_TX:
			begin
				pads_fw = 1'b1;
			end
			default:
			begin
				// an unused code falls back to the safest regime
				pads_quiet = 1'b1;
			end
		endcase
	end

	// the bank is uniform, so one loop body serves every pad
	for (genvar pad_i = 0; pad_i < PSS_PADS; pad_i++)
	begin : g_pad
		logic pad_drive;
		logic pad_listen;
		logic pad_pull;

		// power-down is checked first so no regime can light a pad
		always_comb
		begin
			pad_drive  = 1'b0;
			pad_listen = 1'b0;
			pad_pull   = 1'b0;
			if (pads_quiet)
			begin
				pad_pull = 1'b0;
			end
			else if (pads_held)
			begin
				pad_pull = 1'b1;
			end
			else if (pads_default)
			begin
				pad_listen = 1'b1;
				pad_pull   = 1'b1;
			end
			else if (pads_fw)
			begin
				pad_drive  = FW_OUT_EN[pad_i];
				pad_listen = !FW_OUT_EN[pad_i];
				pad_pull   = FW_PULL_EN[pad_i];
			end
		end

		assign out_nxt[pad_i]  = pad_drive;
		assign in_nxt[pad_i]   = pad_listen;
		assign pull_nxt[pad_i] = pad_pull;
	end

	assign pad_nxt = {out_nxt, in_nxt, pull_nxt};

	// registered so pads never glitch through a decode
	always_ff @(posedge CORE_CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
			PAD_CTL <= '0;
		else
			PAD_CTL <= pad_nxt;
	end

	assign POWER_STATE = state_r;

endmodule : pss_top

/* File: verification/pss_host.sv */
`timescale 1ns/100ps
module pss_host
(
	input logic	clk,
	input logic	on,
	output logic	en = 1'b0,
	output logic	rst_n = 1'b0,
	output logic	io = 1'b0
);
	int	cnt = 0;
	// 5 ms scaled to 4 cycles; all pins fall together on power-down
	always @(posedge clk)
	begin
		#1;
		cnt <= on && en ? cnt + 1 : 0;
		io <= on;
		en <= on && io;
		rst_n <= on && cnt >= 4;
	end
endmodule : pss_host

/* File: verification/pss_monitor.sv */
`timescale 1ns/100ps
module pss_monitor
(
	input logic			CORE_CLK,
	input logic			SYS_RST,
	input logic			CHIP_ENABLE,
	input logic			ACTIVE_LOW_RESET_PIN_N,
	input logic			IO_SUPPLY_GOOD,
	input logic [pss_pkg::PSS_PADS-1:0]	FW_OUT_EN,
	input logic [pss_pkg::PSS_PADS-1:0]	FW_PULL_EN,
	input pss_pkg::pss_activity_type	FW_ACTIVITY,
	input logic				CORE_CONVERTER_ON,
	input pss_pkg::pss_pad_ctl_type		PAD_CTL,
	input pss_pkg::pss_state_type		POWER_STATE
);
	import pss_pkg::*;
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (SYS_RST);
	sequence s_hard_rst;
		(CHIP_ENABLE && IO_SUPPLY_GOOD && !ACTIVE_LOW_RESET_PIN_N) [*4];
	endsequence
	a_reset_pads: assert property (s_hard_rst |->
		POWER_STATE == PSS_RESET && PAD_CTL == 27'h00001ff) else $error("rst");
	a_off_pads: assert property (!CHIP_ENABLE [*4] |->
		POWER_STATE == PSS_OFF && PAD_CTL == 27'h0) else $error("off");
	a_conv_on: assert property (CHIP_ENABLE [*4] |-> CORE_CONVERTER_ON)
		else $error("conv");
	a_conv_off: assert property (!CHIP_ENABLE [*4] |-> !CORE_CONVERTER_ON)
		else $error("conv off");
	a_default_pads: assert property (POWER_STATE == PSS_DEFAULT |->
		PAD_CTL == 27'h003ffff) else $error("dflt");
	a_fw_pads: assert property (POWER_STATE inside {PSS_DOZE, PSS_RX, PSS_TX} |->
		PAD_CTL == {$past(FW_OUT_EN), ~$past(FW_OUT_EN), $past(FW_PULL_EN)})
		else $error("fw");
	a_activity_state: assert property (POWER_STATE[2] |->
		POWER_STATE[0] == ($past(FW_ACTIVITY) == PSS_ACT_TX)) else $error("act");
endmodule : pss_monitor
bind pss_top pss_monitor u_pss_monitor(.*);

/* File: verification/pss_tb_top.sv */
`timescale 1ns/100ps
module pss_tb_top;
	import pss_pkg::*;
	logic	clk = 0, rst = 1, on = 0, cfg = 0, en, rn, io, conv;
	logic [8:0]	oe = 0, pu = 0;
	logic [31:0]	lf = 32'h47c3d08a;
	logic [2:0]	p2, est;
	logic [2:0]	pin_q[$] = '{3'h0, 3'h0};
	logic [26:0]	epad;
	pss_activity_type	act = PSS_ACT_DOZE;
	pss_pad_ctl_type	pad;
	pss_state_type	st;
	int	err_count = 0, n_checks = 0;
	always #12.5 clk = ~clk;
	pss_host u_pss_host(.clk, .on, .en, .rst_n(rn), .io);
	pss_top u_pss_top(.CORE_CLK(clk), .SYS_RST(rst), .CHIP_ENABLE(en),
		.ACTIVE_LOW_RESET_PIN_N(rn), .IO_SUPPLY_GOOD(io), .FW_CONFIGURED(cfg),
		.FW_OUT_EN(oe), .FW_PULL_EN(pu), .FW_ACTIVITY(act),
		.CORE_CONVERTER_ON(conv), .PAD_CTL(pad), .POWER_STATE(st));
	always @(posedge clk)
	begin
		// pins reach the state two edges after the flops first see them
		if (rst)
			pin_q = '{3'h0, 3'h0, 3'h0};
		else
			pin_q.push_back({en, rn, io});
		p2 = pin_q.pop_front();
		est <= !p2[0] || !p2[2] ? PSS_OFF : !p2[1] ? PSS_RESET : !cfg ?
			PSS_DEFAULT : act == PSS_ACT_TX ? PSS_TX : act == PSS_ACT_RX ?
			PSS_RX : PSS_DOZE;
		epad <= {oe, ~oe, pu};
	end
	task chk(logic [26:0] a, b);
		n_checks++;
		if (a !== b)
		begin
			err_count++;
			$display("[FAIL] %0t got %h exp %h", $time, a, b);
		end
	endtask : chk
	always @(negedge clk)
		if (!rst)
		begin
			chk(st, est);
			chk(conv, est != PSS_OFF);
			chk(pad, est == PSS_OFF ? 27'h0 : est == PSS_RESET ? 27'h1ff : est == PSS_DEFAULT ? 27'h3ffff : epad);
		end
	function automatic logic [31:0] lfsr_next(logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : lfsr_next
	task complete_run;
		if (err_count == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : complete_run
	initial
	begin
		#50000;
		err_count++;
		complete_run;
	end
	initial
	begin
		repeat (12) @(posedge clk);
		#1 rst = 0;
		repeat (2)
		begin
			on = 1;
			repeat (16) @(posedge clk);
			repeat (60)
			begin
				@(posedge clk) #1 lf = lfsr_next(lf);
				{oe, pu} = lf[17:0];
				act = pss_activity_type'(lf[19:18]);
				cfg = |lf[22:20];
			end
			on = 0;
			repeat (10) @(posedge clk);
			#1;
		end
		complete_run;
	end
endmodule : pss_tb_top
